// >>> sks_top.sv
// Slider position, neighbour key lockout, scan sequencing and AXI4-Lite registers
`timescale 1ns/100ps
`include "sks_consts.svh"
module sks_top
  import sks_pkg::*;
#(
  parameter int unsigned CYCLE_CLKS = `SKS_CYCLE_CLKS
) (
  input  logic        clk_in,
  input  logic        rst_in,
  input  logic [7:0]  s_axi_awaddr_in,
  input  logic        s_axi_awvalid_in,
  output logic        s_axi_awready_out,
  input  logic [31:0] s_axi_wdata_in,
  input  logic [3:0]  s_axi_wstrb_in,
  input  logic        s_axi_wvalid_in,
  output logic        s_axi_wready_out,
  output logic [1:0]  s_axi_bresp_out,
  output logic        s_axi_bvalid_out,
  input  logic        s_axi_bready_in,
  input  logic [7:0]  s_axi_araddr_in,
  input  logic        s_axi_arvalid_in,
  output logic        s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0]  s_axi_rresp_out,
  output logic        s_axi_rvalid_out,
  input  logic        s_axi_rready_in,
  output logic        acq_req_out,
  output logic [3:0]  acq_key_out,
  output logic [7:0]  acq_pulses_out,
  input  logic        acq_valid_in,
  input  sks_acq_t    acq_in,
  output logic [15:0] key_status_out,
  output logic [7:0]  slider_pos_out,
  output logic        slider_active_out,
  output logic        irq_out,
  output logic        change_out,
  output logic        change_oe_out
);
  localparam int NK   = `SKS_NKEYS;
  localparam int DLW  = `SKS_DELTA_W;
  localparam int DENW = DLW + 6;
  localparam int NUMW = DLW + 14;

  logic [31:0]        ctrl;
  logic [31:0]        grp;
  logic [31:0]        pulse [4];
  logic [`SKS_EV_W-1:0] istat;
  logic [`SKS_EV_W-1:0] imask;
  logic [`SKS_EV_W-1:0] ev_set;
  logic [`SKS_EV_W-1:0] ev_clr;
  sks_ctrl_t          cfg;
  logic [3:0]         sl_len;
  logic [3:0]         res;
  logic [NK-1:0]      sl_mask;
  logic [7:0]         pcnt [NK];
  logic [1:0]         gsel [NK];

  logic               aw_hold;
  logic               w_hold;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               wr_fire;
  logic [31:0]        rd_word;

  sks_state_t         state;
  logic [31:0]        cyc_cnt;
  logic               cycle_tick;
  logic [3:0]         key_idx;
  logic [DLW-1:0]     delta [NK];
  logic [NK-1:0]      det;
  logic [NK-1:0]      key_status;
  logic [NK-1:0]      next_status;
  logic [7:0]         pos;
  logic [7:0]         quo;
  logic               div_done;

  logic [16:0]        cand_det;
  logic [1:0]         cand_grp [17];
  logic [DLW-1:0]     cand_str [17];
  logic [4:0]         owner [3];
  logic               own_vld [3];
  logic [4:0]         next_owner [3];
  logic               next_vld [3];
  logic [DENW-1:0]    pos_wsum;
  logic [DENW-1:0]    pos_sum;
  logic [NUMW-1:0]    pos_num;
  logic [DENW-1:0]    pos_den;

  // True for the word addresses that hold a register
  function automatic logic sks_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `SKS_OFS_PULSE3);
  endfunction : sks_mapped

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] sks_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : sks_merge

  // Configuration fields: a slider length below 2 turns the slider off, other out-of-range values clamped
  assign cfg    = sks_ctrl_t'(ctrl);
  assign sl_len = (cfg.len < 4'd2) ? 4'd0 : ((cfg.len > 4'(`SKS_MAX_SLIDER)) ? 4'(`SKS_MAX_SLIDER) : cfg.len);
  assign res    = (cfg.res < 4'(`SKS_MIN_RES)) ? 4'(`SKS_MIN_RES) :
                  ((cfg.res > 4'(`SKS_MAX_RES)) ? 4'(`SKS_MAX_RES) : cfg.res);

  // Key k sits on receive line k/8 and drive line k%8; slider grows from key 0
  always_comb begin
    for (int k = 0; k < NK; k++) begin
      sl_mask[k] = (4'(k) < sl_len) && (k < `SKS_MAX_SLIDER);
      pcnt[k]    = pulse[k / 4][8 * (k % 4) +: 8];
      gsel[k]    = grp[2 * k +: 2];
    end
  end

  // AXI write address and data are caught independently, in either order
  assign s_axi_awready_out = !aw_hold;
  assign s_axi_wready_out  = !w_hold;
  assign wr_fire           = aw_hold && w_hold && !s_axi_bvalid_out;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && !aw_hold) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_hold) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
    end
  end

  // Write response, one cycle after both halves are in
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `SKS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= sks_mapped(aw_addr) ? `SKS_RESP_OKAY : `SKS_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Writable configuration registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl  <= `SKS_CTRL_RST;
      grp   <= `SKS_GROUP_RST;
      imask <= '0;
      for (int i = 0; i < 4; i++) pulse[i] <= `SKS_PULSE_RST;
    end else if (wr_fire) begin
      case (aw_addr)
        `SKS_OFS_CTRL:  ctrl  <= sks_merge(ctrl, w_data, w_strb) & 32'h0000_ffff;
        `SKS_OFS_GROUP: grp   <= sks_merge(grp, w_data, w_strb);
        `SKS_OFS_IMASK: if (w_strb[0]) imask <= w_data[`SKS_EV_W-1:0];
        default: begin
          if (sks_mapped(aw_addr) && aw_addr >= `SKS_OFS_PULSE0)
            pulse[2'((aw_addr - `SKS_OFS_PULSE0) >> 2)] <=
              sks_merge(pulse[2'((aw_addr - `SKS_OFS_PULSE0) >> 2)], w_data, w_strb);
        end
      endcase
    end
  end

  // Sticky events; a set in the clearing cycle survives
  assign ev_clr = (wr_fire && aw_addr == `SKS_OFS_ISTAT && w_strb[0]) ? w_data[`SKS_EV_W-1:0] : '0;

  always_ff @(posedge clk_in) begin
    if (rst_in) istat <= '0;
    else istat <= (istat & ~ev_clr) | ev_set;
  end

  assign irq_out       = |(istat & imask);
  assign change_out    = 1'b0;
  assign change_oe_out = istat[`SKS_EV_CHG];

  // Read data selection
  always_comb begin
    case (s_axi_araddr_in)
      `SKS_OFS_CTRL:  rd_word = ctrl;
      `SKS_OFS_KEYS:  rd_word = {15'h0, slider_active_out, key_status};
      `SKS_OFS_POS:   rd_word = {24'h00_0000, pos};
      `SKS_OFS_ISTAT: rd_word = {29'h0, istat};
      `SKS_OFS_IMASK: rd_word = {29'h0, imask};
      `SKS_OFS_GROUP: rd_word = grp;
      default: begin
        if (sks_mapped(s_axi_araddr_in) && s_axi_araddr_in >= `SKS_OFS_PULSE0)
          rd_word = pulse[2'((s_axi_araddr_in - `SKS_OFS_PULSE0) >> 2)];
        else
          rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Read channel: address taken while no data is pending
  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `SKS_RESP_OKAY;
    end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_word;
      s_axi_rresp_out  <= sks_mapped(s_axi_araddr_in) ? `SKS_RESP_OKAY : `SKS_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // Fixed scan cycle divider
  assign cycle_tick = (cyc_cnt == 32'(CYCLE_CLKS - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in || cycle_tick) cyc_cnt <= 32'h0000_0000;
    else cyc_cnt <= cyc_cnt + 32'h0000_0001;
  end

  // Scan sequencer: one request per enabled key, then evaluate
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state          <= SKS_ST_IDLE;
      key_idx        <= 4'h0;
      acq_pulses_out <= 8'h00;
    end else begin
      case (state)
        SKS_ST_IDLE: begin
          if (cycle_tick) begin
            state   <= SKS_ST_SCAN;
            key_idx <= 4'h0;
          end
        end
        SKS_ST_SCAN: begin
          if (pcnt[key_idx] == 8'h00) begin
            if (key_idx == 4'hf) state <= SKS_ST_EVAL;
            key_idx <= key_idx + 4'h1;
          end else begin
            state          <= SKS_ST_WAIT;
            acq_pulses_out <= pcnt[key_idx];
          end
        end
        SKS_ST_WAIT: begin
          if (acq_valid_in) begin
            state   <= (key_idx == 4'hf) ? SKS_ST_EVAL : SKS_ST_SCAN;
            key_idx <= key_idx + 4'h1;
          end
        end
        SKS_ST_EVAL: state <= SKS_ST_POS;
        SKS_ST_POS:  if (div_done) state <= SKS_ST_IDLE;
        default:     state <= SKS_ST_IDLE;
      endcase
    end
  end

  assign acq_req_out = (state == SKS_ST_WAIT);
  assign acq_key_out = key_idx;

  // Signal strength per key; a skipped key reads as no signal
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int k = 0; k < NK; k++) delta[k] <= '0;
    end else if (state == SKS_ST_WAIT && acq_valid_in) begin
      delta[key_idx] <= acq_in.delta;
    end else if (state == SKS_ST_SCAN && pcnt[key_idx] == 8'h00) begin
      delta[key_idx] <= '0;
    end
  end

  sks_integrator #(
    .NKEYS (NK)
  ) u_integ (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .upd_in     (state == SKS_ST_WAIT && acq_valid_in),
    .skip_in    (state == SKS_ST_SCAN && pcnt[key_idx] == 8'h00),
    .key_in     (key_idx),
    .above_in   (acq_in.above),
    .limit_in   (cfg.limit),
    .detect_out (det)
  );

  // Lockout candidates: free keys plus the slider as one object at index 16
  always_comb begin
    cand_det[16] = |(det & sl_mask);
    cand_grp[16] = gsel[0];
    cand_str[16] = '0;
    for (int k = 0; k < NK; k++) begin
      cand_det[k] = det[k] && !sl_mask[k];
      cand_grp[k] = gsel[k];
      cand_str[k] = delta[k];
      if (sl_mask[k] && det[k] && delta[k] > cand_str[16]) cand_str[16] = delta[k];
    end
  end

  // Per group: keep a still-touched owner, else pick the strongest
  always_comb begin
    logic [DLW-1:0] best;
    best = '0;
    for (int g = 0; g < 3; g++) begin
      next_owner[g] = owner[g];
      next_vld[g]   = own_vld[g] && cand_det[owner[g]] && (cand_grp[owner[g]] == 2'(g + 1));
      best          = '0;
      if (!next_vld[g]) begin
        for (int c = 0; c < 17; c++) begin
          if (cand_det[c] && cand_grp[c] == 2'(g + 1) && (!next_vld[g] || cand_str[c] > best)) begin
            next_vld[g]   = 1'b1;
            next_owner[g] = 5'(c);
            best          = cand_str[c];
          end
        end
      end
    end
  end

  // Reported status from the owners of the coming cycle
  always_comb begin
    for (int k = 0; k < NK; k++) begin
      if (sl_mask[k]) begin
        if (cand_grp[16] == 2'b00) next_status[k] = det[k];
        else next_status[k] = det[k] && next_vld[cand_grp[16] - 2'd1] &&
                              next_owner[cand_grp[16] - 2'd1] == 5'd16;
      end else if (gsel[k] == 2'b00) begin
        next_status[k] = det[k];
      end else begin
        next_status[k] = next_vld[gsel[k] - 2'd1] && next_owner[gsel[k] - 2'd1] == 5'(k);
      end
    end
  end

  // Owners and reported status change once per scan cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      key_status <= '0;
      for (int g = 0; g < 3; g++) begin
        owner[g]   <= 5'h00;
        own_vld[g] <= 1'b0;
      end
    end else if (state == SKS_ST_EVAL) begin
      key_status <= next_status;
      for (int g = 0; g < 3; g++) begin
        owner[g]   <= next_owner[g];
        own_vld[g] <= next_vld[g];
      end
    end
  end

  // Centroid of slider signals, scaled to 0..255 before the divide
  always_comb begin
    pos_wsum = '0;
    pos_sum  = '0;
    for (int i = 0; i < `SKS_MAX_SLIDER; i++) begin
      if (sl_mask[i]) begin
        pos_wsum = pos_wsum + DENW'(delta[i]) * DENW'(i);
        pos_sum  = pos_sum + DENW'(delta[i]);
      end
    end
    pos_num = (NUMW'(pos_wsum) << 8) - NUMW'(pos_wsum);
    pos_den = (sl_len == 4'd0) ? '0 : DENW'(pos_sum * DENW'(sl_len - 4'd1));
  end

  sks_divider #(
    .NW (NUMW),
    .DW (DENW)
  ) u_div (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (state == SKS_ST_EVAL),
    .num_in   (pos_num),
    .den_in   (pos_den),
    .quo_out  (quo),
    .done_out (div_done)
  );

  // Position follows the slider only while it reports a touch
  always_ff @(posedge clk_in) begin
    if (rst_in) pos <= 8'h00;
    else if (state == SKS_ST_POS && div_done && slider_active_out)
      pos <= quo >> (4'(`SKS_MAX_RES) - res);
  end

  // Events: status change, new position, cycle overrun
  always_comb begin
    ev_set               = '0;
    ev_set[`SKS_EV_CHG]  = (state == SKS_ST_EVAL) && (next_status != key_status);
    ev_set[`SKS_EV_POS]  = (state == SKS_ST_POS) && div_done && slider_active_out &&
                           (pos != (quo >> (4'(`SKS_MAX_RES) - res)));
    ev_set[`SKS_EV_OVR]  = cycle_tick && (state != SKS_ST_IDLE);
  end

  assign key_status_out    = key_status;
  assign slider_pos_out    = pos;
  assign slider_active_out = |(key_status & sl_mask);
endmodule : sks_top

// >>> sks_consts.svh
// Register map, field positions, reset values and timing counts of the slider and lockout block
`ifndef SKS_CONSTS_SVH
`define SKS_CONSTS_SVH

`define SKS_OFS_CTRL    8'h00
`define SKS_OFS_KEYS    8'h04
`define SKS_OFS_POS     8'h08
`define SKS_OFS_ISTAT   8'h0c
`define SKS_OFS_IMASK   8'h10
`define SKS_OFS_GROUP   8'h14
`define SKS_OFS_PULSE0  8'h18
`define SKS_OFS_PULSE3  8'h24

`define SKS_EV_CHG      0
`define SKS_EV_POS      1
`define SKS_EV_OVR      2
`define SKS_EV_W        3

`define SKS_CTRL_RST    32'h0000_0480
`define SKS_GROUP_RST   32'h0000_0000
`define SKS_PULSE_RST   32'h0808_0808

`define SKS_DELTA_W     12
`define SKS_NKEYS       16
`define SKS_MAX_SLIDER  8
`define SKS_MAX_RES     8
`define SKS_MIN_RES     2

`define SKS_CYCLE_MS    16
`define SKS_CLK_KHZ     100000
`define SKS_CYCLE_CLKS  (`SKS_CYCLE_MS * `SKS_CLK_KHZ)

`define SKS_RESP_OKAY   2'b00
`define SKS_RESP_SLVERR 2'b10

`endif

// >>> sks_pkg.sv
// Types shared by the slider and lockout block
`include "sks_consts.svh"
package sks_pkg;
  // One acquisition result from the front end
  typedef struct packed {
    logic                      above;
    logic [`SKS_DELTA_W-1:0]   delta;
  } sks_acq_t;

  // Control word layout
  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0]  limit;
    logic [3:0]  res;
    logic [3:0]  len;
  } sks_ctrl_t;

  typedef enum logic [2:0] {
    SKS_ST_IDLE = 3'b000,
    SKS_ST_SCAN = 3'b001,
    SKS_ST_WAIT = 3'b010,
    SKS_ST_EVAL = 3'b011,
    SKS_ST_POS  = 3'b100
  } sks_state_t;
endpackage : sks_pkg

// >>> sks_integrator.sv
// Per-key detection integrators
`timescale 1ns/100ps
module sks_integrator #(
  parameter int NKEYS = 16
) (
  input  logic             clk_in,
  input  logic             rst_in,
  input  logic             upd_in,
  input  logic             skip_in,
  input  logic [3:0]       key_in,
  input  logic             above_in,
  input  logic [7:0]       limit_in,
  output logic [NKEYS-1:0] detect_out
);
  logic [7:0] cnt [NKEYS];
  logic [7:0] lim;

  // A zero limit would detect with no touch at all
  assign lim = (limit_in == 8'h00) ? 8'h01 : limit_in;

  // Count successive hits, saturate at the limit, clear on a miss
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int k = 0; k < NKEYS; k++) cnt[k] <= 8'h00;
    end else if (upd_in) begin
      if (!above_in) cnt[key_in] <= 8'h00;
      else if (cnt[key_in] < lim) cnt[key_in] <= cnt[key_in] + 8'h01;
    end else if (skip_in) begin
      cnt[key_in] <= 8'h00;
    end
  end

  // Detect once the counter has reached the limit
  always_comb begin
    for (int k = 0; k < NKEYS; k++) detect_out[k] = (cnt[k] >= lim);
  end
endmodule : sks_integrator

// >>> sks_divider.sv
// Eight-step divider for a quotient known to be below 256
`timescale 1ns/100ps
module sks_divider #(
  parameter int NW = 26,
  parameter int DW = 18
) (
  input  logic          clk_in,
  input  logic          rst_in,
  input  logic          start_in,
  input  logic [NW-1:0] num_in,
  input  logic [DW-1:0] den_in,
  output logic [7:0]    quo_out,
  output logic          done_out
);
  logic [NW-1:0] rem;
  logic [NW-1:0] dsh;
  logic [2:0]    step;
  logic          busy;

  // Divisor aligned to the current quotient bit
  assign dsh = NW'(den_in) << step;

  // Restoring division, one quotient bit per cycle, MSB first
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy     <= 1'b0;
      step     <= 3'h0;
      rem      <= '0;
      quo_out  <= 8'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        busy    <= (den_in != '0);
        done_out <= (den_in == '0);
        rem     <= num_in;
        step    <= 3'h7;
        quo_out <= 8'h00;
      end else if (busy) begin
        if (rem >= dsh) begin
          rem          <= rem - dsh;
          quo_out[step] <= 1'b1;
        end
        if (step == 3'h0) begin
          busy     <= 1'b0;
          done_out <= 1'b1;
        end else begin
          step <= step - 3'h1;
        end
      end
    end
  end
endmodule : sks_divider

// >>> sks_top_props.sv
// Port checker of the slider and lockout block
`timescale 1ns/100ps
module sks_top_props (
  input logic        clk_in,
  input logic        rst_in,
  input logic        s_axi_arvalid_in,
  input logic        s_axi_arready_out,
  input logic        s_axi_rvalid_out,
  input logic        acq_req_out,
  input logic [3:0]  acq_key_out,
  input logic [7:0]  acq_pulses_out,
  input logic        acq_valid_in,
  input logic [15:0] key_status_out,
  input logic [7:0]  slider_pos_out,
  input logic        slider_active_out,
  input logic        change_out,
  input logic        change_oe_out
);
  // One clock domain, so one clocking and one reset for all
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_od_low; change_out == 1'b0; endproperty
  a_od_low: assert property (p_od_low) else $error("notice pin data not low");
  property p_notice; $changed(key_status_out) |-> ##[0:1] change_oe_out; endproperty
  a_notice: assert property (p_notice) else $error("status change without notice");
  property p_pos_hold; $changed(slider_pos_out) |-> slider_active_out; endproperty
  a_pos_hold: assert property (p_pos_hold) else $error("position moved with slider idle");
  property p_active; slider_active_out |-> key_status_out[7:0] != 8'h00; endproperty
  a_active: assert property (p_active) else $error("slider active with no receive line zero key");
  property p_skip; acq_req_out |-> acq_pulses_out != 8'h00; endproperty
  a_skip: assert property (p_skip) else $error("disabled key was scanned");
  property p_steady; $changed(key_status_out) |=> $stable(key_status_out) [*8]; endproperty
  a_steady: assert property (p_steady) else $error("status changed twice in a scan");
  property p_req_hold; acq_req_out && !acq_valid_in |=> acq_req_out && $stable(acq_key_out); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before answer");
  property p_req_drop; acq_req_out && acq_valid_in |=> !acq_req_out; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request stayed after answer");
  property p_rd_ans; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered next cycle");
endmodule : sks_top_props

// >>> sks_fe_model.sv
// Behavioural acquisition front end facing the block
`timescale 1ns/100ps
module sks_fe_model
  import sks_pkg::*;
(
  input  logic              clk_in,
  input  logic              rst_in,
  input  logic              req_in,
  input  logic [3:0]        key_in,
  input  logic [15:0]       touch_in,
  input  logic [15:0][11:0] delta_in,
  input  logic              slow_in,
  output logic              valid_out = 1'b0,
  output sks_acq_t          acq_out = '0
);
  logic [3:0] wait_cnt = 4'h0;
  // Answer promptly or late; result bus toggles when not valid so stale data never looks good
  always @(posedge clk_in) begin
    valid_out <= 1'b0;
    acq_out <= rst_in ? '0 : ~acq_out;
    if (rst_in || !req_in || valid_out) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt == (slow_in ? 4'h4 : 4'h0)) begin
      valid_out <= 1'b1;
      acq_out <= {touch_in[key_in], touch_in[key_in] ? delta_in[key_in] : 12'h000};
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : sks_fe_model

// >>> sks_top_tb.sv
// Self-checking bench of the slider and lockout block
`timescale 1ns/100ps
`include "sks_consts.svh"
`define CHK(w, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", w, e, g); end end
module sks_top_tb;
  import sks_pkg::*;
  localparam int CYC = 200;
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, req, valid, active, irq, chg, chg_oe;
  logic [7:0]        awaddr = 8'h00, araddr = 8'h00, pulses, pos;
  logic [31:0]       wdata = 32'h0, rdata, rd;
  logic [1:0]        bresp, rresp, resp;
  logic [3:0]        key;
  logic [15:0]       status, touch = 16'h0;
  logic [15:0][11:0] delta = '0;
  sks_acq_t          acq;
  int                mismatches = 0, total_checks = 0, cycles = 0;

  sks_top #(.CYCLE_CLKS(CYC)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .acq_req_out(req), .acq_key_out(key), .acq_pulses_out(pulses), .acq_valid_in(valid), .acq_in(acq),
    .key_status_out(status), .slider_pos_out(pos), .slider_active_out(active), .irq_out(irq),
    .change_out(chg), .change_oe_out(chg_oe));
  sks_fe_model fe (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .key_in(key), .touch_in(touch),
    .delta_in(delta), .slow_in(slow), .valid_out(valid), .acq_out(acq));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // Hang guard, well above the twenty-odd scans used
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Each channel released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      if (bvalid) resp = bresp;
    end while (bready);
    #1;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
      if (rvalid) rd = rdata;
      if (rvalid) resp = rresp;
    end while (rready);
    #1;
  endtask : rd_reg
  // Touches change at the first request of a scan; a fast answer for key 0 may carry the old one, so key 0 stays idle
  task automatic run(input logic [15:0] t, input int n);
    @(posedge clk_in);
    while (!(req && key == 4'h0)) @(posedge clk_in);
    touch <= t;
    repeat ((n - 1) * CYC + 190) @(posedge clk_in);
    #1;
  endtask : run

  task automatic t_regs;
    rd_reg(`SKS_OFS_CTRL);
    `CHK("ctrl reset", `SKS_CTRL_RST, rd)
    rd_reg(`SKS_OFS_PULSE0);
    `CHK("pulse reset", `SKS_PULSE_RST, rd)
    rd_reg(8'h28);
    `CHK("unmapped read", `SKS_RESP_SLVERR, resp)
    wr(8'h02, 32'h0);
    `CHK("misaligned write", `SKS_RESP_SLVERR, resp)
  endtask : t_regs
  // Integrator limit two, a broken run must start over
  task automatic t_detect;
    wr(`SKS_OFS_CTRL, 32'h0000_0280);
    wr(`SKS_OFS_IMASK, 32'h1);
    delta[3] <= 12'd100;
    slow <= 1'b1;
    run(16'h0008, 1);
    `CHK("one sample", 16'h0000, status)
    run(16'h0000, 1);
    run(16'h0008, 1);
    `CHK("after break", 16'h0000, status)
    run(16'h0008, 1);
    `CHK("detected", 16'h0008, status)
    `CHK("notice", 1'b1, chg_oe)
    `CHK("irq set", 1'b1, irq)
    wr(`SKS_OFS_IMASK, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    wr(`SKS_OFS_ISTAT, 32'h1);
    wr(`SKS_OFS_IMASK, 32'h1);
    `CHK("irq cleared", 1'b0, irq)
    `CHK("notice cleared", 1'b0, chg_oe)
    slow <= 1'b0;
  endtask : t_detect
  // Keys 9 and 10 share group one, key 11 is exempt
  task automatic t_lockout;
    wr(`SKS_OFS_CTRL, 32'h0000_0180);
    wr(`SKS_OFS_GROUP, 32'h0014_0000);
    delta[9] <= 12'd100;
    delta[10] <= 12'd200;
    delta[11] <= 12'd50;
    run(16'h0a00, 2);
    `CHK("exempt key", 16'h0a00, status)
    run(16'h0e00, 2);
    `CHK("owner kept", 16'h0a00, status)
    run(16'h0c00, 2);
    `CHK("owner moved", 16'h0c00, status)
    run(16'h0000, 1);
    run(16'h0600, 2);
    `CHK("one per group", 16'h0400, status)
  endtask : t_lockout
  // Four key slider in group one with plain key 5, key 6 disabled
  task automatic t_slider;
    wr(`SKS_OFS_CTRL, 32'h0000_0184);
    wr(`SKS_OFS_GROUP, 32'h0000_0455);
    wr(`SKS_OFS_PULSE0 + 8'h04, 32'h0800_0808);
    delta[1] <= 12'd100;
    delta[2] <= 12'd100;
    delta[5] <= 12'd100;
    delta[6] <= 12'd100;
    run(16'h0046, 2);
    `CHK("slider keys", 16'h0006, status)
    `CHK("slider active", 1'b1, active)
    `CHK("pos 8 bit", 8'd127, pos)
    rd_reg(`SKS_OFS_ISTAT);
    `CHK("pos event", 1'b1, rd[`SKS_EV_POS])
    wr(`SKS_OFS_CTRL, 32'h0000_0124);
    run(16'h0066, 2);
    `CHK("slider wins", 16'h0006, status)
    `CHK("pos 2 bit", 8'd1, pos)
    wr(`SKS_OFS_ISTAT, 32'h2);
    run(16'h0020, 2);
    `CHK("key after slider", 16'h0020, status)
    `CHK("pos held", 8'd1, pos)
    rd_reg(`SKS_OFS_ISTAT);
    `CHK("no pos event", 1'b0, rd[`SKS_EV_POS])
    run(16'h0026, 2);
    `CHK("key wins", 16'h0020, status)
    wr(`SKS_OFS_CTRL, 32'h0000_0182);
    run(16'h0004, 2);
    `CHK("past slider", 16'h0004, status)
    `CHK("slider short", 1'b0, active)
  endtask : t_slider

  // Reset for eight cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_detect();
    t_lockout();
    t_slider();
    stop_test();
  end
endmodule : sks_top_tb

bind sks_top sks_top_props u_props (.clk_in, .rst_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .acq_req_out, .acq_key_out, .acq_pulses_out, .acq_valid_in, .key_status_out, .slider_pos_out,
  .slider_active_out, .change_out, .change_oe_out);
